// ===== verilog/smt_cfg.svh
// Notes on behaviour
// - Duty mode: fall latches width, rise latches period.
// - Single duty acquisition clears go on rise.
// - High/low: rise starts, fall latches width, restarts.
// - High/low: next rise latches period, restarts.
// - Windowed: later window rises latch period, restart.
// - Gated window: count while input high.
// - Flight: window starts, input rise latches period.
// - Flight: second window rise before any input rise latches width.
// - Capture: window rise period, fall width.
// - Capture: only software or period match resets the counter.
// - Counter: input pulses count, window fall latches.
// - Gated counter: count while window active.
// - Windowed counter: width on fall, period later.
// - Latch updates set flags, each enabled.
// - Sync modes trigger on prescaled clock only.
// - Counter equal period sets match flag.
// - Enable low resets state, keeps registers.
// - Halt holds at period, else wraps zero.
// - Window polarity bit inverts window input.
// - Input polarity bit inverts measured input.
// - Clock polarity picks counting clock edge.
// - Prescale divides clock by 1,2,4,8.
// - Single acquisition stops; repeat keeps overwriting.
// - Mode codes timer through windowed counter.
// - Every mode rolls over at period match unless halt set.
//
// Purpose: register map and constants of the measurement timer
// Assumes: byte-wide register port
// Notes:   definitions only
`ifndef SMT_CFG_SVH
`define SMT_CFG_SVH
`define SMT_A_CTRL0    5'h00
`define SMT_A_CTRL1    5'h01
`define SMT_A_STAT     5'h02
`define SMT_A_CNT      5'h03
`define SMT_A_CPW      5'h06
`define SMT_A_CPR      5'h09
`define SMT_A_PRV      5'h0C
`define SMT_A_IFLAG    5'h0F
`define SMT_A_IEN      5'h10
`define SMT_STAT_RST   5
`define SMT_CNT_ZERO   24'h000000
`define SMT_CNT_RELOAD 24'h000001
`define SMT_PRV_RST    24'hFFFFFF
`define SMT_PS_ZERO    3'h0
`endif

// ===== verilog/smt_pkg.sv
// Purpose: types of the measurement timer
// Assumes: nothing
// Notes:   mode order follows the hardware codes
package smt_pkg;
    typedef enum logic [3:0] {
        SMT_TIMER, SMT_GATED_TIMER, SMT_DUTY, SMT_HILO, SMT_WIN_MEAS,
        SMT_GATED_WIN, SMT_FLIGHT, SMT_CAPTURE, SMT_COUNTER,
        SMT_GATED_CNT, SMT_WIN_CNT
    } smt_mode_t;
    typedef struct packed {
        logic       en;
        logic       rsv;
        logic       halt_at_match;
        logic       window_polarity;
        logic       input_polarity;
        logic       clock_polarity;
        logic [1:0] prescale_select;
    } smt_ctrl0_t;
    typedef struct packed {
        logic       acquire_go;
        logic       repeat_en;
        logic [1:0] rsv;
        smt_mode_t  mode;
    } smt_ctrl1_t;
    typedef struct packed {
        logic [4:0] rsv;
        logic       match;
        logic       period;
        logic       width;
    } smt_irq_t;
    typedef struct packed {
        logic [4:0] rsv;
        logic       running;
        logic       window_open;
        logic       acquiring;
    } smt_stat_t;
endpackage : smt_pkg

// ===== verilog/smt_edge.sv
// Purpose: polarity-corrected level and edge strobes of one input
// Assumes: input synchronous to mclk_i
// Notes:   history only advances on a sample strobe
`timescale 1ns/100ps
`default_nettype none
module smt_edge (
    input  wire logic mclk_i,    // Clock
    input  wire logic rst_n_i,   // Async reset
    input  wire logic clr_i,     // Forget history
    input  wire logic sig_i,     // Raw input
    input  wire logic pol_i,     // Invert when set
    input  wire logic smp_i,     // Sample strobe
    output var  logic level_o,   // Active level
    output var  logic rise_o,    // Active edge
    output var  logic fall_o     // Inactive edge
);
    logic prev_reg;

    assign level_o = sig_i ^ pol_i;
    assign rise_o  = smp_i & level_o & ~prev_reg;
    assign fall_o  = smp_i & ~level_o & prev_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
        end else if (clr_i) begin
            prev_reg <= 1'b0;
        end else if (smp_i) begin
            prev_reg <= level_o;
        end
    end
endmodule : smt_edge
`default_nettype wire

// ===== verilog/smt_core.sv
// Purpose: 24-bit signal measurement timer with byte register port
// Assumes: all pins synchronous to mclk_i; selected clock slower than mclk_i
// Notes:   read data valid in the cycle after the read strobe only
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "smt_cfg.svh"
module smt_core #(
    parameter int AW = 5,
    parameter int CW = 24
) (
    input  wire logic          mclk_i,      // 40 MHz clock
    input  wire logic          rst_n_i,     // Async reset
    input  wire logic [AW-1:0] addr_i,      // Register address
    input  wire logic [7:0]    wdata_i,     // Write data
    input  wire logic          wr_i,        // Write strobe
    input  wire logic          rd_i,        // Read strobe
    output logic      [7:0]    rdata_o,     // Read data
    input  wire logic          sel_clk_i,   // Selected measurement clock
    input  wire logic          meas_i,      // Measured input
    input  wire logic          win_i,       // Window input
    output logic               clk_req_o,   // Clock request
    output logic      [2:0]    irq_o        // Enabled flags: match,period,width
);
    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    smt_pkg::smt_ctrl0_t ctrl0_reg;
    smt_pkg::smt_ctrl1_t ctrl1_reg;
    smt_pkg::smt_irq_t   flag_reg;
    smt_pkg::smt_irq_t   ien_reg;
    smt_pkg::smt_irq_t   flag_next;
    smt_pkg::smt_stat_t  stat_w;
    logic [CW-1:0]       cnt_reg;
    logic [CW-1:0]       cpw_reg;
    logic [CW-1:0]       cpr_reg;
    logic [CW-1:0]       prv_reg;
    logic [7:0]          rdata_reg;
    logic                armed_reg;
    logic                armed_next;
    logic [2:0]          ps_reg;

    // Mode decode outputs
    logic                inc;
    logic                load;
    logic [CW-1:0]       ld_val;
    logic                cap_w;
    logic                cap_p;
    logic                done;
    logic                act;
    logic                async_m;
    logic                tick;
    logic                pulse;
    logic                smp;
    logic                m_lvl;
    logic                m_rise;
    logic                m_fall;
    logic                w_lvl;
    logic                w_rise;
    logic                w_fall;
    logic                c_edge;
    logic                sw_rst;
    logic                match;
    logic                en;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [CW-1:0] put_byte(input logic [CW-1:0] old,
                                               input logic [AW-1:0] ofs,
                                               input logic [7:0] d);
        logic [CW-1:0] v;
        v = old;
        case (ofs)
            5'h00:   v[7:0]   = d;
            5'h01:   v[15:8]  = d;
            5'h02:   v[23:16] = d;
            default: v = old;
        endcase
        return v;
    endfunction : put_byte

    function automatic logic [7:0] get_byte(input logic [CW-1:0] v,
                                            input logic [AW-1:0] ofs);
        logic [7:0] b;
        b = 8'h00;
        case (ofs)
            5'h00:   b = v[7:0];
            5'h01:   b = v[15:8];
            5'h02:   b = v[23:16];
            default: b = 8'h00;
        endcase
        return b;
    endfunction : get_byte

    function automatic logic in_word(input logic [AW-1:0] a,
                                     input logic [AW-1:0] base);
        return (a >= base) && (a < base + 5'h03);
    endfunction : in_word

    function automatic logic [2:0] ps_mask(input logic [1:0] ps);
        return 3'((4'h1 << ps) - 4'h1);
    endfunction : ps_mask

    // ---------------------------------------------------------------
    // Input conditioning
    // ---------------------------------------------------------------
    assign en        = ctrl0_reg.en;
    assign clk_req_o = en;
    assign async_m   = ctrl1_reg.mode >= smt_pkg::SMT_COUNTER;
    assign act       = en & ctrl1_reg.acquire_go;

    // Chosen clock edge after polarity
    smt_edge u_clk (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (~en),
        .sig_i   (sel_clk_i),
        .pol_i   (ctrl0_reg.clock_polarity),
        .smp_i   (1'b1),
        .level_o (),
        .rise_o  (c_edge),
        .fall_o  ()
    );

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ps_reg <= `SMT_PS_ZERO;
        end else if (!en) begin
            ps_reg <= `SMT_PS_ZERO;
        end else if (c_edge) begin
            ps_reg <= (ps_reg == ps_mask(ctrl0_reg.prescale_select))
                      ? `SMT_PS_ZERO : ps_reg + 3'h1;
        end
    end

    assign tick = c_edge & (ps_reg == ps_mask(ctrl0_reg.prescale_select));
    // Sync modes see inputs only on the prescaled clock
    assign smp   = async_m ? 1'b1 : tick;
    assign pulse = async_m ? m_rise : tick;

    smt_edge u_meas (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (~en),
        .sig_i   (meas_i),
        .pol_i   (ctrl0_reg.input_polarity),
        .smp_i   (smp),
        .level_o (m_lvl),
        .rise_o  (m_rise),
        .fall_o  (m_fall)
    );

    smt_edge u_win (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (~en),
        .sig_i   (win_i),
        .pol_i   (ctrl0_reg.window_polarity),
        .smp_i   (smp),
        .level_o (w_lvl),
        .rise_o  (w_rise),
        .fall_o  (w_fall)
    );

    // ---------------------------------------------------------------
    // Mode decode
    // ---------------------------------------------------------------
    always_comb begin
        inc        = 1'b0;
        load       = 1'b0;
        ld_val     = `SMT_CNT_ZERO;
        cap_w      = 1'b0;
        cap_p      = 1'b0;
        done       = 1'b0;
        armed_next = armed_reg;
        case (ctrl1_reg.mode)
            smt_pkg::SMT_TIMER: begin
                inc = pulse;
            end
            smt_pkg::SMT_GATED_TIMER: begin
                inc   = pulse & m_lvl;
                cap_w = m_fall;
                done  = m_fall;
            end
            smt_pkg::SMT_DUTY: begin
                inc   = pulse;
                cap_w = m_fall;
                if (m_rise) begin
                    cap_p  = 1'b1;
                    load   = 1'b1;
                    ld_val = `SMT_CNT_RELOAD;
                    done   = 1'b1;
                end
            end
            smt_pkg::SMT_HILO: begin
                inc = pulse & armed_reg;
                if (m_fall && armed_reg) begin
                    cap_w = 1'b1;
                    load  = 1'b1;
                end
                if (m_rise) begin
                    cap_p      = armed_reg;
                    done       = armed_reg;
                    load       = 1'b1;
                    armed_next = 1'b1;
                end
            end
            smt_pkg::SMT_WIN_MEAS, smt_pkg::SMT_GATED_WIN: begin
                inc = pulse & armed_reg;
                if (ctrl1_reg.mode == smt_pkg::SMT_GATED_WIN) begin
                    inc = pulse & armed_reg & m_lvl;
                end
                if (w_rise) begin
                    cap_p      = armed_reg;
                    done       = armed_reg;
                    load       = 1'b1;
                    armed_next = 1'b1;
                end
            end
            smt_pkg::SMT_FLIGHT: begin
                inc = pulse & armed_reg;
                if (w_rise) begin
                    cap_w      = armed_reg;
                    load       = 1'b1;
                    armed_next = 1'b1;
                end else if (m_rise && armed_reg) begin
                    cap_p      = 1'b1;
                    load       = 1'b1;
                    done       = 1'b1;
                    armed_next = 1'b0;
                end
            end
            smt_pkg::SMT_CAPTURE: begin
                inc   = pulse;
                cap_p = w_rise;
                cap_w = w_fall;
                done  = w_rise;
            end
            smt_pkg::SMT_COUNTER: begin
                inc   = pulse;
                cap_w = w_fall;
                done  = w_fall;
            end
            smt_pkg::SMT_GATED_CNT: begin
                inc = pulse & w_lvl & armed_reg;
                if (w_rise) begin
                    armed_next = 1'b1;
                end
                if (w_fall) begin
                    cap_w      = 1'b1;
                    done       = 1'b1;
                    armed_next = 1'b0;
                end
            end
            smt_pkg::SMT_WIN_CNT: begin
                inc   = pulse & armed_reg;
                cap_w = w_fall & armed_reg;
                if (w_rise) begin
                    cap_p      = armed_reg;
                    done       = armed_reg;
                    armed_next = 1'b1;
                end
            end
            default: begin
                inc = 1'b0;
            end
        endcase
    end

    assign match  = act & inc & ~load & (cnt_reg == prv_reg);
    assign sw_rst = wr_i & (addr_i == `SMT_A_STAT) & wdata_i[`SMT_STAT_RST];

    // ---------------------------------------------------------------
    // Acquisition state
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_reg <= 1'b0;
        end else if (!act) begin
            armed_reg <= 1'b0;
        end else begin
            armed_reg <= armed_next;
        end
    end

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= `SMT_CNT_ZERO;
        end else if (sw_rst) begin
            cnt_reg <= `SMT_CNT_ZERO;
        end else if (wr_i && in_word(addr_i, `SMT_A_CNT)) begin
            cnt_reg <= put_byte(cnt_reg, addr_i - `SMT_A_CNT, wdata_i);
        end else if (act && load) begin
            cnt_reg <= ld_val;
        end else if (match) begin
            cnt_reg <= ctrl0_reg.halt_at_match
                       ? prv_reg : `SMT_CNT_ZERO;
        end else if (act && inc) begin
            cnt_reg <= cnt_reg + 24'h000001;
        end
    end

    // ---------------------------------------------------------------
    // Latches and period value
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpw_reg <= `SMT_CNT_ZERO;
            cpr_reg <= `SMT_CNT_ZERO;
        end else begin
            if (act && cap_w) begin
                cpw_reg <= cnt_reg;
            end
            if (act && cap_p) begin
                cpr_reg <= cnt_reg;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prv_reg <= `SMT_PRV_RST;
        end else if (wr_i && in_word(addr_i, `SMT_A_PRV)) begin
            prv_reg <= put_byte(prv_reg, addr_i - `SMT_A_PRV, wdata_i);
        end
    end

    // ---------------------------------------------------------------
    // Control
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl0_reg <= '0;
        end else if (wr_i && addr_i == `SMT_A_CTRL0) begin
            ctrl0_reg     <= smt_pkg::smt_ctrl0_t'(wdata_i);
            ctrl0_reg.rsv <= 1'b0;
        end
    end

    // Software write wins over the hardware clear of go
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl1_reg <= '0;
        end else if (wr_i && addr_i == `SMT_A_CTRL1) begin
            ctrl1_reg     <= smt_pkg::smt_ctrl1_t'(wdata_i);
            ctrl1_reg.rsv <= 2'h0;
        end else if (act && done && !ctrl1_reg.repeat_en) begin
            ctrl1_reg.acquire_go <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Flags: write one to clear, a new event wins
    // ---------------------------------------------------------------
    always_comb begin
        flag_next = flag_reg;
        if (wr_i && addr_i == `SMT_A_IFLAG) begin
            flag_next = flag_reg & ~smt_pkg::smt_irq_t'(wdata_i);
        end
        flag_next.width  = flag_next.width | (act & cap_w);
        flag_next.period = flag_next.period | (act & cap_p);
        flag_next.match  = flag_next.match | match;
        flag_next.rsv    = 5'h00;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ien_reg <= '0;
        end else if (wr_i && addr_i == `SMT_A_IEN) begin
            ien_reg     <= smt_pkg::smt_irq_t'(wdata_i);
            ien_reg.rsv <= 5'h00;
        end
    end

    assign irq_o = {flag_reg.match & ien_reg.match,
                    flag_reg.period & ien_reg.period,
                    flag_reg.width & ien_reg.width};

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_comb begin
        stat_w             = '0;
        stat_w.running     = act;
        stat_w.window_open = en & w_lvl;
        stat_w.acquiring   = en & m_lvl;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (!rd_i) begin
            rdata_reg <= 8'h00;
        end else if (in_word(addr_i, `SMT_A_CNT)) begin
            rdata_reg <= get_byte(cnt_reg, addr_i - `SMT_A_CNT);
        end else if (in_word(addr_i, `SMT_A_CPW)) begin
            rdata_reg <= get_byte(cpw_reg, addr_i - `SMT_A_CPW);
        end else if (in_word(addr_i, `SMT_A_CPR)) begin
            rdata_reg <= get_byte(cpr_reg, addr_i - `SMT_A_CPR);
        end else if (in_word(addr_i, `SMT_A_PRV)) begin
            rdata_reg <= get_byte(prv_reg, addr_i - `SMT_A_PRV);
        end else begin
            case (addr_i)
                `SMT_A_CTRL0: rdata_reg <= ctrl0_reg;
                `SMT_A_CTRL1: rdata_reg <= ctrl1_reg;
                `SMT_A_STAT:  rdata_reg <= stat_w;
                `SMT_A_IFLAG: rdata_reg <= flag_reg;
                `SMT_A_IEN:   rdata_reg <= ien_reg;
                default:      rdata_reg <= 8'h00;
            endcase
        end
    end

    assign rdata_o = rdata_reg;
endmodule : smt_core
`default_nettype wire

// ===== sim/smt_core_asserts.sv
// Purpose: port-level checks of the measurement timer
// Assumes: register offsets from the shared header
// Notes:   captures are seen only through the enabled flag outputs
`timescale 1ns/100ps
`default_nettype none
`include "smt_cfg.svh"
module smt_core_asserts #(
    parameter int AW = 5
) (
    input wire logic          mclk_i,    // Clock
    input wire logic          rst_n_i,   // Async reset
    input wire logic [AW-1:0] addr_i,    // Address
    input wire logic [7:0]    wdata_i,   // Write data
    input wire logic          wr_i,      // Write strobe
    input wire logic          rd_i,      // Read strobe
    input wire logic [7:0]    rdata_o,   // Read data
    input wire logic          clk_req_o, // Clock request
    input wire logic [2:0]    irq_o      // Enabled flags
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    a_read_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property (rd_i && addr_i > 5'h10 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_mode_rsv_zero: assert property (
        rd_i && addr_i == `SMT_A_CTRL1 |=> rdata_o[5:4] == 2'b00)
        else $error("reserved control bits read nonzero");
    a_enable_drives_req: assert property (
        wr_i && addr_i == `SMT_A_CTRL0 |=> clk_req_o == $past(wdata_i[7]))
        else $error("clock request does not follow enable");
    a_req_holds: assert property (
        !(wr_i && addr_i == `SMT_A_CTRL0) |=> $stable(clk_req_o))
        else $error("clock request moved without write");
    a_irq_masked_off: assert property (
        wr_i && addr_i == `SMT_A_IEN && wdata_i == 8'h00 |=> irq_o == 3'b000)
        else $error("interrupt seen with all enables clear");
    a_match_only_irq: assert property (
        wr_i && addr_i == `SMT_A_IEN && wdata_i == 8'h04 |=> irq_o[1:0] == 2'b00)
        else $error("capture interrupt seen while masked");
    a_idle_no_capture: assert property (
        !clk_req_o && !$past(clk_req_o) && !$past(wr_i) |-> !$rose(irq_o[1]) && !$rose(irq_o[0]))
        else $error("capture flag rose while disabled");
    c_both_capt: cover property (irq_o[1:0] == 2'b11);
    c_match: cover property (irq_o[2]);
    c_enable: cover property ($rose(clk_req_o));
endmodule : smt_core_asserts
bind smt_core smt_core_asserts #(.AW(AW)) u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .clk_req_o(clk_req_o), .irq_o(irq_o));
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: register-driven scenarios of the measurement timer
// Assumes: selected clock runs free at a quarter of mclk_i
// Notes:   timings judged by latch differences, immune to sync latency
`timescale 1ns/100ps
`default_nettype none
`include "smt_cfg.svh"
module tb_top;
    logic        mclk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0;
    logic        sel_clk_i = 0, meas_i = 0, win_i = 0;
    logic [4:0]  addr_i = 5'h00;
    logic [7:0]  wdata_i = 8'h00, rdata_o, b;
    logic        clk_req_o;
    logic [2:0]  irq_o;
    logic [1:0]  div = 2'h0;
    logic [23:0] v, w;
    int          num_errors = 0, compares = 0;
    smt_core #(.AW(5), .CW(24)) DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sel_clk_i(sel_clk_i),
        .meas_i(meas_i), .win_i(win_i), .clk_req_o(clk_req_o), .irq_o(irq_o));
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        div <= div + 2'h1;
        if (div[0]) sel_clk_i <= ~sel_clk_i;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task conclude;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task chk(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask : wr
    task rd(input logic [4:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge mclk_i);
    endtask : rd
    task rd3(input logic [4:0] a, output logic [23:0] q);
        logic [7:0] t;
        for (int i = 0; i < 3; i++) begin
            rd(a + 5'(i), t);
            q[8*i +: 8] = t;
        end
    endtask : rd3
    // Free-running clock keeps every wait bounded
    task edges(input int n);
        repeat (n) @(posedge sel_clk_i);
        @(posedge mclk_i);
    endtask : edges
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        #1000000;
        num_errors++;
        conclude();
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(`SMT_A_CTRL0, b);
        chk("ctrl0 reset", 24'h0, 24'(b));
        rd3(`SMT_A_PRV, v);
        chk("period value reset", 24'hFFFFFF, v);
        rd(5'h1F, b);
        chk("unmapped", 24'h0, 24'(b));
        wr(`SMT_A_IEN, 8'h03);
        for (int p = 0; p < 4; p++) begin
            wr(`SMT_A_CTRL0, 8'h80 | 8'(p));
            wr(`SMT_A_CTRL1, 8'hC7);
            edges(8);
            win_i <= 1'b1;
            edges(16);
            win_i <= 1'b0;
            edges(8);
            wr(`SMT_A_CTRL1, 8'h47);
            rd3(`SMT_A_CPR, v);
            rd3(`SMT_A_CPW, w);
            chk("capture span", 24'd16 >> p, w - v);
            wr(`SMT_A_CTRL0, 8'h00);
        end
        chk("capture irq", 24'h3, 24'(irq_o));
        wr(`SMT_A_IFLAG, 8'h07);
        rd(`SMT_A_IFLAG, b);
        chk("flags cleared", 24'h0, 24'(b));
        wr(`SMT_A_CTRL0, 8'h80);
        wr(`SMT_A_CTRL1, 8'hC2);
        edges(4);
        meas_i <= 1'b1;
        edges(8);
        meas_i <= 1'b0;
        edges(12);
        meas_i <= 1'b1;
        edges(4);
        wr(`SMT_A_CTRL1, 8'h42);
        rd3(`SMT_A_CPR, v);
        rd3(`SMT_A_CPW, w);
        chk("duty low time", 24'd12, v - w);
        meas_i <= 1'b0;
        edges(4);
        wr(`SMT_A_CTRL1, 8'h82);
        edges(4);
        meas_i <= 1'b1;
        edges(4);
        rd(`SMT_A_CTRL1, b);
        chk("single go cleared", 24'h02, 24'(b));
        wr(`SMT_A_PRV, 8'h05);
        wr(`SMT_A_PRV + 5'h1, 8'h00);
        wr(`SMT_A_PRV + 5'h2, 8'h00);
        wr(`SMT_A_CTRL1, 8'h00);
        wr(`SMT_A_IEN, 8'h04);
        wr(`SMT_A_CTRL0, 8'hA0);
        wr(`SMT_A_STAT, 8'h20);
        wr(`SMT_A_CTRL1, 8'h80);
        edges(12);
        chk("match irq", 24'h4, 24'(irq_o));
        wr(`SMT_A_CTRL1, 8'h00);
        rd3(`SMT_A_CNT, v);
        chk("halt count", 24'h5, v);
        wr(`SMT_A_CTRL0, 8'h80);
        wr(`SMT_A_STAT, 8'h20);
        wr(`SMT_A_CTRL1, 8'h80);
        edges(20);
        wr(`SMT_A_CTRL1, 8'h00);
        rd3(`SMT_A_CNT, v);
        chk("wrap bound", 24'h1, 24'(v < 24'h6));
        // Counter mode: three measured pulses inside one window
        meas_i <= 1'b0;
        edges(1);
        wr(`SMT_A_STAT, 8'h20);
        wr(`SMT_A_CTRL1, 8'hC8);
        win_i <= 1'b1;
        edges(1);
        repeat (3) begin
            meas_i <= 1'b1;
            edges(1);
            meas_i <= 1'b0;
            edges(1);
        end
        win_i <= 1'b0;
        edges(1);
        wr(`SMT_A_CTRL1, 8'h48);
        rd3(`SMT_A_CPW, w);
        chk("pulse count", 24'h3, w);
        wr(`SMT_A_CTRL0, 8'h00);
        chk("clock request", 24'h0, 24'(clk_req_o));
        rd(`SMT_A_PRV, b);
        chk("kept period", 24'h05, 24'(b));
        wr(`SMT_A_IEN, 8'h00);
        conclude();
    end
endmodule : tb_top
`default_nettype wire
